// >>> common/pmbus_fault_limit_defs.vh
`ifndef PMBUS_FAULT_LIMIT_DEFS_VH
`define PMBUS_FAULT_LIMIT_DEFS_VH

// Command codes of the bank
`define CMD_UV_LIM      8'h44
`define CMD_UV_ACT      8'h45
`define CMD_OC_LIM      8'h46
`define CMD_OC_ACT      8'h47
`define CMD_OC_WARN     8'h4A
`define CMD_OT_LIM      8'h4F
`define CMD_OT_ACT      8'h50
`define CMD_OT_WARN     8'h51
`define CMD_VINOV_LIM   8'h55
`define CMD_VINOV_ACT   8'h56
`define CMD_VINUV_WARN  8'h58
`define CMD_PG_ON       8'h5E
`define CMD_PG_OFF      8'h5F
`define CMD_TON_DLY     8'h60
`define CMD_TURN_ON_RISE_TIME    8'h61
`define CMD_TON_MAX     8'h62
`define CMD_TON_ACT     8'h63
`define CMD_TOFF_DLY    8'h64
`define CMD_TURN_OFF_FALL_TIME   8'h65
`define CMD_STATUS      8'h78

// Storage index of each command
`define IDX_UV_LIM      5'd0
`define IDX_UV_ACT      5'd1
`define IDX_OC_LIM      5'd2
`define IDX_OC_ACT      5'd3
`define IDX_OC_WARN     5'd4
`define IDX_OT_LIM      5'd5
`define IDX_OT_ACT      5'd6
`define IDX_OT_WARN     5'd7
`define IDX_VINOV_LIM   5'd8
`define IDX_VINOV_ACT   5'd9
`define IDX_VINUV_WARN  5'd10
`define IDX_PG_ON       5'd11
`define IDX_PG_OFF      5'd12
`define IDX_TON_DLY     5'd13
`define IDX_TURN_ON_RISE_TIME    5'd14
`define IDX_TON_MAX     5'd15
`define IDX_TON_ACT     5'd16
`define IDX_TOFF_DLY    5'd17
`define IDX_TURN_OFF_FALL_TIME   5'd18
`define NUM_REGS        19

// Fault action encodings
`define ACT_IGNORE       8'h00
`define ACT_SHUTDOWN     8'h80
`define ACT_INHIBIT      8'hC0
`define ACT_PULSE_LATCH  8'h3C
`define ACT_PULSE_HICCUP 8'h3F

// Reset values
`define RST_UV_LIM      16'h0065
`define RST_UV_ACT      16'h0000
`define RST_OC_LIM      16'hF842
`define RST_OC_ACT      16'h003F
`define RST_OC_WARN     16'hF838
`define RST_OT_LIM      16'h0091
`define RST_OT_ACT      16'h00C0
`define RST_OT_WARN     16'h007D
`define RST_VINOV_LIM   16'hF060
`define RST_VINOV_ACT   16'h0080
`define RST_VINUV_WARN  16'hF801
`define RST_PG_ON       16'h002D
`define RST_PG_OFF      16'h002A
`define RST_TON_DLY     16'h0000
`define RST_TURN_ON_RISE_TIME    16'h0002
`define RST_TON_MAX     16'h0000
`define RST_TON_ACT     16'h0000
`define RST_TOFF_DLY    16'h0000
`define RST_TURN_OFF_FALL_TIME   16'h0001

// Timing
`define CLK_PERIOD_NS   5
`define MS_TIME_NS      1000000
`define OC_PULSE_CYCLES 4'd8
`define HICCUP_MS       8'd20

`endif

// >>> rtl/pmbus_fault_limit_command_set.v
// Behaviour
// [R1] Hold 16-bit output undervoltage fault limit, 3.9mV steps, default 0.395V.
// [R2] Output undervoltage action byte: ignore or shutdown, default ignore.
// [R3] Overcurrent fault limit, exponent -1, 3 to 37.5A, default 33A.
// [R4] Overcurrent default: pulse-by-pulse for 8 cycles, then hiccup or latch.
// [R5] Overcurrent warning limit, exponent -1, default 28A, warns when exceeded.
// [R6] Overtemperature fault limit, exponent 0, 0 to 150C, default 145C.
// [R7] Overtemperature action byte: ignore, shutdown or inhibit; inhibit default.
// [R8] Overtemperature warning limit, exponent 0, default 125C, raises warning.
// [R9] Input overvoltage fault limit, exponent -2, 6.25 to 24V, default 24V.
// [R10] Input overvoltage action byte: ignore or shutdown, shutdown default.
// [R11] Input voltage warning limit, exponent -1, 0 to 16V, default 0.5V.
// [R12] Power good asserts at on level, negates at off level, scaled.
// [R13] After start, wait turn-on delay in ms before output rises.
// [R14] Ramp output over programmed rise time in ms, default 2ms.
// [R15] Timeout fault if undervoltage limit not reached in time; zero disables.
// [R16] Turn-on timeout action byte: ignore or shutdown, default ignore.
// [R17] Turn-off delay and fall time accepted and stored but ignored.
// [R18] Status byte: bit 7 busy fault, bit 6 output off.
// [R19] Status bits 5..0: vout OV, OC, vin UV, temp, CML, other.
// [R20] Output voltage thresholds divided by loop scale 1, 0.5, 0.25, 0.125.
// [R21] Shutdown fault turns output off until faults cleared or restart.
// [R22] Host writes words in linear format, action selectors as bytes.
`timescale 1ns/1ps
`include "pmbus_fault_limit_defs.vh"

module pmbus_fault_limit_command_set #(
	parameter MS_CYCLES = (`MS_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        ce,
	input  wire [7:0]  cmdCode,
	input  wire        wrEn,
	input  wire [15:0] wrData,
	input  wire        rdEn,
	output reg  [15:0] rdData_q,
	output reg         rdValid_q,
	output reg         cmdAck_q,
	output reg         cmdError_q,
	input  wire        clearFaults,
	input  wire        enablePin,
	input  wire        onCommand,
	input  wire [1:0]  loopScaleSel,
	input  wire [15:0] voutMeas,
	input  wire [15:0] pgVoutMeas,
	input  wire [10:0] ioutMeas,
	input  wire [10:0] tempMeas,
	input  wire [10:0] vinMeas,
	input  wire        switchCycle,
	input  wire        busyFault,
	input  wire        voutOvFault,
	input  wire        vinUvFault,
	input  wire        cmlFault,
	output reg         outputEnable_q,
	output reg         rampActive_q,
	output reg         currentLimit_q,
	output reg         powerGood_q,
	output reg         ocWarn_q,
	output reg         otWarn_q,
	output reg         vinUvWarn_q,
	output wire [7:0]  statusByte
);

	localparam ST_OFF   = 3'd0;
	localparam ST_DELAY = 3'd1;
	localparam ST_RISE  = 3'd2;
	localparam ST_ON    = 3'd3;
	localparam ST_FAULT = 3'd4;
	localparam [31:0] MS_LAST = MS_CYCLES - 1;

	// Command code to storage index, bit 5 flags a supported code
	function [5:0] decode;
		input [7:0] code;
		begin
			case (code)
				`CMD_UV_LIM:     decode = {1'b1, `IDX_UV_LIM};
				`CMD_UV_ACT:     decode = {1'b1, `IDX_UV_ACT};
				`CMD_OC_LIM:     decode = {1'b1, `IDX_OC_LIM};
				`CMD_OC_ACT:     decode = {1'b1, `IDX_OC_ACT};
				`CMD_OC_WARN:    decode = {1'b1, `IDX_OC_WARN};
				`CMD_OT_LIM:     decode = {1'b1, `IDX_OT_LIM};
				`CMD_OT_ACT:     decode = {1'b1, `IDX_OT_ACT};
				`CMD_OT_WARN:    decode = {1'b1, `IDX_OT_WARN};
				`CMD_VINOV_LIM:  decode = {1'b1, `IDX_VINOV_LIM};
				`CMD_VINOV_ACT:  decode = {1'b1, `IDX_VINOV_ACT};
				`CMD_VINUV_WARN: decode = {1'b1, `IDX_VINUV_WARN};
				`CMD_PG_ON:      decode = {1'b1, `IDX_PG_ON};
				`CMD_PG_OFF:     decode = {1'b1, `IDX_PG_OFF};
				`CMD_TON_DLY:    decode = {1'b1, `IDX_TON_DLY};
				`CMD_TURN_ON_RISE_TIME:   decode = {1'b1, `IDX_TURN_ON_RISE_TIME};
				`CMD_TON_MAX:    decode = {1'b1, `IDX_TON_MAX};
				`CMD_TON_ACT:    decode = {1'b1, `IDX_TON_ACT};
				`CMD_TOFF_DLY:   decode = {1'b1, `IDX_TOFF_DLY};
				`CMD_TURN_OFF_FALL_TIME:  decode = {1'b1, `IDX_TURN_OFF_FALL_TIME};
				default:         decode = 6'h00;
			endcase
		end
	endfunction

	// Power-on value of each entry
	function [15:0] resetValue;
		input [4:0] idx;
		begin
			case (idx)
				`IDX_UV_LIM:     resetValue = `RST_UV_LIM;     // see [R1]
				`IDX_UV_ACT:     resetValue = `RST_UV_ACT;     // see [R2]
				`IDX_OC_LIM:     resetValue = `RST_OC_LIM;     // see [R3]
				`IDX_OC_ACT:     resetValue = `RST_OC_ACT;     // see [R4]
				`IDX_OC_WARN:    resetValue = `RST_OC_WARN;    // see [R5]
				`IDX_OT_LIM:     resetValue = `RST_OT_LIM;     // see [R6]
				`IDX_OT_ACT:     resetValue = `RST_OT_ACT;     // see [R7]
				`IDX_OT_WARN:    resetValue = `RST_OT_WARN;    // see [R8]
				`IDX_VINOV_LIM:  resetValue = `RST_VINOV_LIM;  // see [R9]
				`IDX_VINOV_ACT:  resetValue = `RST_VINOV_ACT;  // see [R10]
				`IDX_VINUV_WARN: resetValue = `RST_VINUV_WARN; // see [R11]
				`IDX_PG_ON:      resetValue = `RST_PG_ON;      // see [R12]
				`IDX_PG_OFF:     resetValue = `RST_PG_OFF;     // see [R12]
				`IDX_TON_DLY:    resetValue = `RST_TON_DLY;    // see [R13]
				`IDX_TURN_ON_RISE_TIME:   resetValue = `RST_TURN_ON_RISE_TIME;   // see [R14]
				`IDX_TON_MAX:    resetValue = `RST_TON_MAX;    // see [R15]
				`IDX_TON_ACT:    resetValue = `RST_TON_ACT;    // see [R16]
				`IDX_TOFF_DLY:   resetValue = `RST_TOFF_DLY;   // see [R17]
				`IDX_TURN_OFF_FALL_TIME:  resetValue = `RST_TURN_OFF_FALL_TIME;  // see [R17]
				default:         resetValue = 16'h0000;
			endcase
		end
	endfunction

	// Action selectors keep one byte only
	function isByte;
		input [4:0] idx;
		begin
			isByte = (idx == `IDX_UV_ACT) || (idx == `IDX_OC_ACT) ||
				(idx == `IDX_OT_ACT) || (idx == `IDX_VINOV_ACT) ||
				(idx == `IDX_TON_ACT);
		end
	endfunction

	wire [5:0]  dec    = decode(cmdCode);
	wire        hit    = dec[5];
	wire [4:0]  hitIdx = dec[4:0];
	wire [15:0] regVal [0:`NUM_REGS-1];

	// One storage word per command; byte selectors drop the upper lane
	genvar g;
	generate
		for (g = 0; g < `NUM_REGS; g = g + 1) begin : gEntry
			reg [15:0] val_q;
			always @(posedge mclk) begin
				if (!nrst) begin
					val_q <= resetValue(g[4:0]);
				end else if (ce && wrEn && hit && hitIdx == g[4:0]) begin
					if (isByte(g[4:0])) // see [R22]
						val_q <= {8'h00, wrData[7:0]};
					else
						val_q <= wrData; // see [R17]
				end
			end
			assign regVal[g] = val_q;
		end
	endgenerate

	// Field views; turn-off entries are stored but never read here
	wire [15:0] uvLim    = regVal[`IDX_UV_LIM];
	wire [7:0]  uvAct    = regVal[`IDX_UV_ACT][7:0];
	wire [10:0] ocLim    = regVal[`IDX_OC_LIM][10:0];
	wire [7:0]  ocAct    = regVal[`IDX_OC_ACT][7:0];
	wire [10:0] ocWarnLim = regVal[`IDX_OC_WARN][10:0];
	wire [10:0] otLim    = regVal[`IDX_OT_LIM][10:0];
	wire [7:0]  otAct    = regVal[`IDX_OT_ACT][7:0];
	wire [10:0] otWarnLim = regVal[`IDX_OT_WARN][10:0];
	wire [10:0] vinOvLim = regVal[`IDX_VINOV_LIM][10:0];
	wire [7:0]  vinOvAct = regVal[`IDX_VINOV_ACT][7:0];
	wire [9:0]  vinUvLim = regVal[`IDX_VINUV_WARN][9:0];
	wire [15:0] pgOnLim  = regVal[`IDX_PG_ON];
	wire [15:0] pgOffLim = regVal[`IDX_PG_OFF];
	wire [7:0]  tonDly   = {1'b0, regVal[`IDX_TON_DLY][6:0]};
	wire [7:0]  tonRise  = {1'b0, regVal[`IDX_TURN_ON_RISE_TIME][6:0]};
	wire [7:0]  tonMax   = {1'b0, regVal[`IDX_TON_MAX][6:0]};
	wire [7:0]  tonAct   = regVal[`IDX_TON_ACT][7:0];

	// Enable pin comes from outside, two flops before use
	reg enSync1_q;
	reg enSync2_q;
	always @(posedge mclk) begin
		if (!nrst) begin
			enSync1_q <= 1'b0;
			enSync2_q <= 1'b0;
		end else if (ce) begin
			enSync1_q <= enablePin;
			enSync2_q <= enSync1_q;
		end
	end
	wire startCond = enSync2_q & onCommand; // see [R13]

	// Output thresholds divided by loop scale, i.e. shifted left
	wire [18:0] uvThr  = {3'b000, uvLim} << loopScaleSel;    // see [R20]
	wire [18:0] pgOnThr  = {3'b000, pgOnLim} << loopScaleSel;  // see [R20]
	wire [18:0] pgOffThr = {3'b000, pgOffLim} << loopScaleSel; // see [R20]

	// Comparators on the measurement words
	wire uvLow     = {3'b000, voutMeas} < uvThr;             // see [R1]
	wire ocOver    = ioutMeas > ocLim;                       // see [R3]
	wire ocWarnNow = ioutMeas > ocWarnLim;                   // see [R5]
	wire otOver    = tempMeas >= otLim;                      // see [R6]
	wire otWarnNow = tempMeas >= otWarnLim;                  // see [R8]
	wire vinOver   = vinMeas >= vinOvLim;                    // see [R9]
	wire vinUvNow  = vinMeas < {vinUvLim, 1'b0};             // see [R11]

	reg [2:0]  state_q;
	reg [2:0]  state_d;
	reg [31:0] msPre_q;
	reg [7:0]  msCnt_q;
	reg [7:0]  tonCnt_q;
	reg        reached_q;
	reg [3:0]  pbpCnt_q;
	reg        hiccup_q;
	reg        inhibit_q;
	reg        ocFlag_q;
	reg        tempFlag_q;
	reg        otherFlag_q;

	wire running  = (state_q == ST_RISE) || (state_q == ST_ON);
	wire powering = running || (state_q == ST_DELAY);
	wire msTick   = (msPre_q == MS_LAST);
	wire ocPulse  = (ocAct == `ACT_PULSE_LATCH) ||
		(ocAct == `ACT_PULSE_HICCUP);

	// Fault actions; under-voltage only counts once regulating
	wire uvEvt  = (state_q == ST_ON) && uvLow;
	wire tonEvt = running && !reached_q && tonMax != 8'd0 &&
		tonCnt_q >= tonMax && uvLow;                          // see [R15]
	wire uvTrip = uvEvt && uvAct == `ACT_SHUTDOWN;          // see [R2]
	wire ocTrip = powering && ocOver && (ocAct == `ACT_SHUTDOWN ||
		(ocPulse && pbpCnt_q >= `OC_PULSE_CYCLES));           // see [R4]
	wire otTrip = otOver && otAct == `ACT_SHUTDOWN;         // see [R7]
	wire otInh  = otOver && otAct == `ACT_INHIBIT;          // see [R7]
	wire vinTrip = vinOver && vinOvAct == `ACT_SHUTDOWN;    // see [R10]
	wire tonTrip = tonEvt && tonAct == `ACT_SHUTDOWN;       // see [R16]
	wire trip = uvTrip || ocTrip || otTrip || otInh || vinTrip || tonTrip;

	// Sequencer next state
	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFF: begin
				if (startCond)
					state_d = ST_DELAY;
			end
			ST_DELAY, ST_RISE, ST_ON: begin
				if (!startCond)
					state_d = ST_OFF;
				else if (trip)
					state_d = ST_FAULT; // see [R21]
				else if (state_q == ST_DELAY && msCnt_q >= tonDly)
					state_d = ST_RISE; // see [R13]
				else if (state_q == ST_RISE && msCnt_q >= tonRise)
					state_d = ST_ON; // see [R14]
			end
			ST_FAULT: begin
				if (!startCond || clearFaults)
					state_d = ST_OFF; // see [R21]
				else if (hiccup_q && !ocOver && msCnt_q >= `HICCUP_MS)
					state_d = ST_DELAY;
				else if (inhibit_q && !otOver)
					state_d = ST_DELAY;
			end
			default: state_d = ST_OFF;
		endcase
	end

	// State, millisecond prescaler and counters restart on each change
	always @(posedge mclk) begin
		if (!nrst) begin
			state_q <= ST_OFF;
			msPre_q <= 32'h0000_0000;
			msCnt_q <= 8'h00;
		end else if (ce) begin
			state_q <= state_d;
			if (state_d != state_q || msTick)
				msPre_q <= 32'h0000_0000;
			else
				msPre_q <= msPre_q + 32'h0000_0001;
			if (state_d != state_q)
				msCnt_q <= 8'h00;
			else if (msTick && msCnt_q != 8'hFF)
				msCnt_q <= msCnt_q + 8'h01;
		end
	end

	// Turn-on timeout runs from start of rise until limit reached
	always @(posedge mclk) begin
		if (!nrst) begin
			tonCnt_q  <= 8'h00;
			reached_q <= 1'b0;
		end else if (ce) begin
			if (!running) begin
				tonCnt_q  <= 8'h00;
				reached_q <= 1'b0;
			end else begin
				if (!uvLow)
					reached_q <= 1'b1; // see [R15]
				if (msTick && tonCnt_q != 8'hFF)
					tonCnt_q <= tonCnt_q + 8'h01;
			end
		end
	end

	// Pulse-by-pulse counter of switching cycles spent in limit
	always @(posedge mclk) begin
		if (!nrst) begin
			pbpCnt_q       <= 4'h0;
			currentLimit_q <= 1'b0;
		end else if (ce) begin
			currentLimit_q <= powering && ocOver && ocPulse; // see [R4]
			if (!(powering && ocOver && ocPulse))
				pbpCnt_q <= 4'h0;
			else if (switchCycle && pbpCnt_q != 4'hF)
				pbpCnt_q <= pbpCnt_q + 4'h1;
		end
	end

	// Restart style is fixed on the way into the fault state
	always @(posedge mclk) begin
		if (!nrst) begin
			hiccup_q  <= 1'b0;
			inhibit_q <= 1'b0;
		end else if (ce && state_d == ST_FAULT && state_q != ST_FAULT) begin
			hiccup_q  <= ocTrip && ocAct == `ACT_PULSE_HICCUP;
			inhibit_q <= otInh && !otTrip && !ocTrip && !uvTrip &&
				!vinTrip && !tonTrip;
		end
	end

	// Sticky summary flags; a new event beats a clear in the same cycle
	always @(posedge mclk) begin
		if (!nrst) begin
			ocFlag_q    <= 1'b0;
			tempFlag_q  <= 1'b0;
			otherFlag_q <= 1'b0;
		end else if (ce) begin
			ocFlag_q    <= (powering && ocOver) ||
				(ocFlag_q & ~clearFaults);                         // see [R19]
			tempFlag_q  <= otOver || (tempFlag_q & ~clearFaults); // see [R19]
			otherFlag_q <= uvEvt || vinOver || tonEvt ||
				(otherFlag_q & ~clearFaults);                      // see [R19]
		end
	end

	// Output controls, warnings and power good with hysteresis
	always @(posedge mclk) begin
		if (!nrst) begin
			outputEnable_q <= 1'b0;
			rampActive_q   <= 1'b0;
			powerGood_q    <= 1'b0;
			ocWarn_q       <= 1'b0;
			otWarn_q       <= 1'b0;
			vinUvWarn_q    <= 1'b0;
		end else if (ce) begin
			outputEnable_q <= (state_d == ST_RISE) || (state_d == ST_ON);
			rampActive_q   <= (state_d == ST_RISE); // see [R14]
			ocWarn_q       <= ocWarnNow;              // see [R5]
			otWarn_q       <= otWarnNow;              // see [R8]
			vinUvWarn_q    <= vinUvNow;               // see [R11]
			if (!running || {3'b000, pgVoutMeas} < pgOffThr)
				powerGood_q <= 1'b0; // see [R12]
			else if ({3'b000, pgVoutMeas} >= pgOnThr)
				powerGood_q <= 1'b1; // see [R12]
		end
	end

	// Summary byte: live pins, the output-off bit and sticky flags
	assign statusByte = {busyFault, !outputEnable_q, voutOvFault,
		ocFlag_q, vinUvFault, tempFlag_q, cmlFault, otherFlag_q}; // see [R18]

	// Command answers, one cycle after the request
	always @(posedge mclk) begin
		if (!nrst) begin
			rdData_q   <= 16'h0000;
			rdValid_q  <= 1'b0;
			cmdAck_q   <= 1'b0;
			cmdError_q <= 1'b0;
		end else if (ce) begin
			rdValid_q  <= rdEn;
			cmdAck_q   <= (rdEn || wrEn) &&
				(hit || (rdEn && cmdCode == `CMD_STATUS));       // see [R17]
			cmdError_q <= (rdEn || wrEn) && !hit &&
				!(rdEn && cmdCode == `CMD_STATUS);
			if (rdEn) begin
				if (hit)
					rdData_q <= regVal[hitIdx];
				else if (cmdCode == `CMD_STATUS)
					rdData_q <= {8'h00, statusByte}; // see [R18]
				else
					rdData_q <= 16'h0000;
			end
		end
	end

endmodule // pmbus_fault_limit_command_set

// >>> verif/pmbus_fault_limit_asserts.sv
`timescale 1ns/1ps
module pmbus_fault_limit_asserts (
	input wire        mclk,
	input wire        nrst,
	input wire        ce,
	input wire [7:0]  cmdCode,
	input wire        wrEn,
	input wire        rdEn,
	input wire [15:0] rdData_q,
	input wire        rdValid_q,
	input wire        cmdAck_q,
	input wire        cmdError_q,
	input wire        busyFault,
	input wire        voutOvFault,
	input wire        vinUvFault,
	input wire        cmlFault,
	input wire        outputEnable_q,
	input wire        rampActive_q,
	input wire [7:0]  statusByte
);
	// One clock domain, so one clocking and one disable for all
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_wordAck;
		ce && wrEn && cmdCode == 8'h46 |=> cmdAck_q && !cmdError_q;
	endproperty
	a_wordAck: assert property (p_wordAck) else $error("word write not acked");

	property p_statusWrErr;
		ce && wrEn && cmdCode == 8'h78 |=> cmdError_q && !cmdAck_q;
	endproperty
	a_statusWrErr: assert property (p_statusWrErr) else $error("status write ok");

	property p_readValid;
		ce && rdEn |=> rdValid_q;
	endproperty
	a_readValid: assert property (p_readValid) else $error("read not valid");

	// Unknown codes must read as zero, never as stale data
	property p_unknownRead;
		ce && rdEn && cmdCode == 8'h00 |=> rdData_q == 16'h0000 && cmdError_q;
	endproperty
	a_unknownRead: assert property (p_unknownRead) else $error("bad unknown read");

	property p_statusRead;
		ce && rdEn && cmdCode == 8'h78 |=> rdData_q == {8'h00, $past(statusByte)};
	endproperty
	a_statusRead: assert property (p_statusRead) else $error("status read wrong");

	property p_offBit;
		statusByte[6] == !outputEnable_q;
	endproperty
	a_offBit: assert property (p_offBit) else $error("output off bit wrong");

	property p_liveBits;
		{statusByte[7], statusByte[5], statusByte[3], statusByte[1]} ==
			{busyFault, voutOvFault, vinUvFault, cmlFault};
	endproperty
	a_liveBits: assert property (p_liveBits) else $error("live status bits");

	property p_rampOn;
		rampActive_q |-> outputEnable_q;
	endproperty
	a_rampOn: assert property (p_rampOn) else $error("ramp with output off");

	property p_riseStart;
		$rose(outputEnable_q) |-> rampActive_q;
	endproperty
	a_riseStart: assert property (p_riseStart) else $error("output on w/o ramp");
endmodule // pmbus_fault_limit_asserts

bind pmbus_fault_limit_command_set pmbus_fault_limit_asserts
	i_pmbus_fault_limit_asserts (.mclk, .nrst, .ce, .cmdCode, .wrEn, .rdEn,
	.rdData_q, .rdValid_q, .cmdAck_q, .cmdError_q, .busyFault, .voutOvFault,
	.vinUvFault, .cmlFault, .outputEnable_q, .rampActive_q, .statusByte);

// >>> verif/pmbus_host_model.sv
`timescale 1ns/1ps
module pmbus_host_model (
	input  wire        mclk,
	output reg  [7:0]  cmdCode,
	output reg         wrEn,
	output reg  [15:0] wrData,
	output reg         rdEn,
	input  wire [15:0] rdData_q,
	input  wire        cmdAck_q,
	input  wire        cmdError_q
);
	initial begin
		cmdCode = 8'h00;
		wrEn = 1'b0;
		wrData = 16'h0000;
		rdEn = 1'b0;
	end

	// Strobe held one edge; bus then scrambled so stale values never match
	task automatic xfer(input logic rd, input logic [7:0] code,
		input logic [15:0] data, output logic [15:0] q,
		output logic [1:0] resp);
		@(posedge mclk);
		cmdCode <= code;
		wrData <= data;
		wrEn <= !rd;
		rdEn <= rd;
		@(posedge mclk);
		wrEn <= 1'b0;
		rdEn <= 1'b0;
		cmdCode <= ~code;
		wrData <= ~data;
		#1;
		q = rdData_q;
		resp = {cmdAck_q, cmdError_q};
	endtask
endmodule // pmbus_host_model

// >>> verif/pmbus_fault_limit_command_set_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checksDone++; if ((a) !== (e)) begin \
	miscompares++; $display("[ERR] %s expected %h seen %h", nm, e, a); end end
`define WAITC(c, n) begin k = 0; \
	while (!(c) && k < n) begin @(posedge mclk); #1; k++; end end
module pmbus_fault_limit_command_set_bench;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        ce = 1'b1;
	logic        clearFaults = 1'b0, enablePin = 1'b0, onCommand = 1'b0;
	logic        switchCycle = 1'b0;
	logic [1:0]  loopScaleSel = 2'h0;
	logic [15:0] voutMeas = 16'h0200, pgVoutMeas = 16'h0000;
	logic [10:0] ioutMeas = 11'h000, tempMeas = 11'h019, vinMeas = 11'h028;
	logic [3:0]  flt = 4'h0;
	wire         busyFault = flt[3], voutOvFault = flt[2];
	wire         vinUvFault = flt[1], cmlFault = flt[0];
	wire [7:0]   cmdCode, statusByte;
	wire [15:0]  wrData, rdData_q;
	wire         wrEn, rdEn, rdValid_q, cmdAck_q, cmdError_q, outputEnable_q;
	wire         rampActive_q, currentLimit_q, powerGood_q;
	wire         ocWarn_q, otWarn_q, vinUvWarn_q;
	int          miscompares = 0, checksDone = 0, k;
	logic [15:0] q;
	logic [1:0]  resp;
	logic [7:0]  codes [19] = '{8'h44, 8'h45, 8'h46, 8'h47, 8'h4A, 8'h4F,
		8'h50, 8'h51, 8'h55, 8'h56, 8'h58, 8'h5E, 8'h5F, 8'h60, 8'h61, 8'h62,
		8'h63, 8'h64, 8'h65};
	logic [15:0] dflt [19] = '{16'h0065, 16'h0000, 16'hF842, 16'h003F,
		16'hF838, 16'h0091, 16'h00C0, 16'h007D, 16'hF060, 16'h0080, 16'hF801,
		16'h002D, 16'h002A, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000,
		16'h0001};

	always #2.5 mclk = ~mclk;

	pmbus_fault_limit_command_set #(.MS_CYCLES(10)) i_pmbus_fault_limit_command_set (
		.mclk, .nrst, .ce, .cmdCode, .wrEn, .wrData, .rdEn, .rdData_q,
		.rdValid_q, .cmdAck_q, .cmdError_q, .clearFaults, .enablePin,
		.onCommand, .loopScaleSel, .voutMeas, .pgVoutMeas, .ioutMeas,
		.tempMeas, .vinMeas, .switchCycle, .busyFault, .voutOvFault,
		.vinUvFault, .cmlFault, .outputEnable_q, .rampActive_q,
		.currentLimit_q, .powerGood_q, .ocWarn_q, .otWarn_q, .vinUvWarn_q,
		.statusByte);
	pmbus_host_model i_pmbus_host_model (.mclk, .cmdCode, .wrEn, .wrData,
		.rdEn, .rdData_q, .cmdAck_q, .cmdError_q);

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		i_pmbus_host_model.xfer(1'b0, c, d, q, resp);
	endtask
	task automatic rd(input logic [7:0] c);
		i_pmbus_host_model.xfer(1'b1, c, 16'h0000, q, resp);
	endtask
	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic pulseClear;
		@(posedge mclk);
		clearFaults <= 1'b1;
		@(posedge mclk);
		clearFaults <= 1'b0;
	endtask

	// Reset values of the whole bank
	task automatic t_defaults;
		for (int i = 0; i < 19; i++) begin
			rd(codes[i]);
			`CHK("default", dflt[i], q)
		end
	endtask

	// Byte selectors keep only the low byte; turn-off words still ack
	task automatic t_readBack;
		logic [15:0] d;
		logic        isByte;
		for (int i = 0; i < 19; i++) begin
			d = 16'hC3A5 ^ 16'(i);
			isByte = codes[i] inside {8'h45, 8'h47, 8'h50, 8'h56, 8'h63};
			wr(codes[i], d);
			`CHK("wrAck", 2'b10, resp)
			rd(codes[i]);
			`CHK("readBack", isByte ? {8'h00, d[7:0]} : d, q)
			wr(codes[i], dflt[i]);
		end
	endtask

	task automatic t_refused;
		wr(8'h78, 16'h00FF);
		`CHK("statusWr", 2'b01, resp)
		rd(8'h00);
		`CHK("unknownRd", 18'h00001, {q, resp})
	endtask

	// Each live fault input lands on its own status bit
	task automatic t_liveStatus;
		logic [3:0] f;
		for (int b = 0; b < 5; b++) begin
			f = 4'h8 >> b;
			@(posedge mclk);
			flt <= f;
			rd(8'h78);
			`CHK("status", {8'h00, f[3], 1'b1, f[2], 1'b0, f[1], 1'b0, f[0], 1'b0}, q)
		end
	endtask

	// Delay of 3 ms then a 2 ms ramp; power good with hysteresis and scale
	task automatic t_start;
		logic [15:0] pgv [6] = '{16'd44, 16'd45, 16'd43, 16'd41, 16'd89, 16'd90};
		logic [5:0]  pge = 6'b100110;
		wr(8'h60, 16'h0003);
		@(posedge mclk);
		enablePin <= 1'b1;
		onCommand <= 1'b1;
		`WAITC(outputEnable_q, 60)
		`CHK("delayLen", 1'b1, k >= 30 && k <= 36)
		`CHK("ramp", 1'b1, rampActive_q)
		`CHK("offBit", 1'b0, statusByte[6])
		`WAITC(!rampActive_q, 40)
		`CHK("riseLen", 1'b1, k >= 19 && k <= 21)
		for (int i = 0; i < 6; i++) begin
			@(posedge mclk);
			pgVoutMeas <= pgv[i];
			loopScaleSel <= (i > 3) ? 2'h1 : 2'h0;
			settle;
			`CHK("powerGood", pge[i], powerGood_q)
		end
		loopScaleSel <= 2'h0;
	endtask

	task automatic t_warn;
		ioutMeas <= 11'd57;
		settle;
		`CHK("ocWarnHi", 1'b1, ocWarn_q)
		ioutMeas <= 11'd56;
		tempMeas <= 11'd126;
		settle;
		`CHK("ocWarnLo", 1'b0, ocWarn_q)
		`CHK("otWarnHi", 1'b1, otWarn_q)
		tempMeas <= 11'd124;
		settle;
		`CHK("otWarnLo", 1'b0, otWarn_q)
		// 0.25 V input is under the 0.5 V default warning level
		vinMeas <= 11'd1;
		settle;
		`CHK("vinUvWarn", 1'b1, vinUvWarn_q)
		vinMeas <= 11'd40;
	endtask

	// Inhibit drops the output and restarts once cooled
	task automatic t_otInhibit;
		tempMeas <= 11'd145;
		`WAITC(!outputEnable_q, 10)
		`CHK("otOff", 2'b01, {outputEnable_q, statusByte[2]})
		tempMeas <= 11'd25;
		`WAITC(outputEnable_q, 100)
		`CHK("otRestart", 1'b1, outputEnable_q)
	endtask

	// Seven cycles over the limit are tolerated, the eighth trips
	task automatic t_ocTrip;
		ioutMeas <= 11'd67;
		for (int i = 0; i < 8; i++) begin
			if (i == 7)
				`CHK("ocEarly", 2'b11, {outputEnable_q, currentLimit_q})
			@(posedge mclk);
			switchCycle <= 1'b1;
			@(posedge mclk);
			switchCycle <= 1'b0;
		end
		`WAITC(!outputEnable_q, 10)
		`CHK("ocTrip", 2'b01, {outputEnable_q, statusByte[4]})
		ioutMeas <= 11'd0;
		`WAITC(outputEnable_q, 400)
		`CHK("hiccup", 1'b1, outputEnable_q && k >= 150)
		pulseClear;
		settle;
		`CHK("cleared", 8'h00, statusByte)
	endtask

	// Input overvoltage shuts down and stays down until cleared
	task automatic t_vinOv;
		vinMeas <= 11'd95;
		settle;
		`CHK("vinBelow", 1'b1, outputEnable_q)
		vinMeas <= 11'd96;
		`WAITC(!outputEnable_q, 10)
		`CHK("vinOff", 2'b01, {outputEnable_q, statusByte[0]})
		vinMeas <= 11'd40;
		repeat (40) @(posedge mclk);
		#1;
		`CHK("heldOff", 1'b0, outputEnable_q)
		pulseClear;
		`WAITC(outputEnable_q, 100)
		`CHK("reenable", 1'b1, outputEnable_q)
	endtask

	// A rise that never clears the limit times out 1 ms in and shuts down
	task automatic t_tonMax;
		wr(8'h62, 16'h0001);
		wr(8'h63, 16'h0080);
		enablePin <= 1'b0;
		settle;
		`CHK("enDrop", 1'b0, outputEnable_q)
		voutMeas <= 16'd50;
		enablePin <= 1'b1;
		`WAITC(outputEnable_q, 60)
		`WAITC(!outputEnable_q, 20)
		`CHK("tonMax", 1'b1, k >= 10 && k <= 12)
		`CHK("tonOff", 2'b11, {statusByte[6], statusByte[0]})
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checksDone, miscompares);
		if (miscompares == 0 && checksDone > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Whole run is under a thousand cycles; this cuts a hang short
	initial begin
		#50000;
		miscompares++;
		tally_and_finish;
	end

	initial begin
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		t_defaults;
		t_readBack;
		t_refused;
		t_liveStatus;
		t_start;
		t_warn;
		t_otInhibit;
		t_ocTrip;
		t_vinOv;
		t_tonMax;
		tally_and_finish;
	end
endmodule // pmbus_fault_limit_command_set_bench
